// >>> verilog/hmc_ctrl.sv
// configuration and sleep-state control bank with its AXI4-Lite slave
`include "hmc_map.svh"
// Notes on behaviour
// R1: start clear: auto fan off, both pwm zero, errors masked; boost on defaults
// R2: start set: masking lifted, auto fan runs on programmed limits
// R3: lock set rejects writes to every lockable bit
// R4: start and lock bits are lockable
// R5: once set, lock clears only by external reset
// R6: global mask suppresses all errors, other registers untouched
// R7: alert follows errors only while alert enable is set
// R8: tie bit joins both processor throttle lines
// R9: software keeps tie clear when lines are joined outside
// R10: ready flag sets itself once all channels have valid data
// R11: software ignores readings until ready is seen
// R12: configuration resets to zero; bits 6:5 reserved but writable
// R13: sleep field bits 1:0; code 00 awake, nothing masked
// R14: code 01 masks by light-sleep masks plus fixed masking
// R15: code 10 masks by suspend masks plus fixed masking
// R16: code 11 deepest masking, forced by external reset
// R17: sleep register bits 7:2 reserved, read as zero
module hmc_ctrl (
	input  wire logic                   sys_clk,
	input  wire logic                   rst,
	input  wire logic [`HMC_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                   s_axi_awvalid,
	output logic                        s_axi_awready,
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output logic                        s_axi_wready,
	output logic [1:0]                  s_axi_bresp,
	output logic                        s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	input  wire logic [`HMC_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                   s_axi_arvalid,
	output logic                        s_axi_arready,
	output logic [31:0]                 s_axi_rdata,
	output logic [1:0]                  s_axi_rresp,
	output logic                        s_axi_rvalid,
	input  wire logic                   s_axi_rready,
	input  wire logic [`HMC_ERR_W-1:0]  errorEvents,
	input  wire logic [`HMC_ERR_W-1:0]  lightSleepMask,
	input  wire logic [`HMC_ERR_W-1:0]  suspendMask,
	input  wire logic [`HMC_ERR_W-1:0]  deepSleepMask,
	input  wire logic                   allChannelsValid,
	input  wire logic [7:0]             pwm1AutoDuty,
	input  wire logic [7:0]             pwm2AutoDuty,
	input  wire logic                   cpu1ThrottleLineIn,
	output logic                        cpu1ThrottleLineOut,
	output logic                        cpu1ThrottleLineOe,
	input  wire logic                   cpu2ThrottleLineIn,
	output logic                        cpu2ThrottleLineOut,
	output logic                        cpu2ThrottleLineOe,
	output hmc_pkg::hmc_fan_t           fan,
	output logic [`HMC_ERR_W-1:0]       passedErrors,
	output logic                        alert,
	output logic                        irq
);
	import hmc_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	hmc_cfg_t              cfg;
	hmc_cfg_t              next_cfg;
	logic [1:0]            sleepStateField;
	logic [1:0]            next_sleepStateField;
	logic                  awHeld;
	logic                  next_awHeld;
	logic [`HMC_ADDR_W-1:0] awAddr;
	logic [`HMC_ADDR_W-1:0] next_awAddr;
	logic                  wHeld;
	logic                  next_wHeld;
	logic [7:0]            wData;
	logic [7:0]            next_wData;
	logic                  wLane0;
	logic                  next_wLane0;
	logic                  next_awready;
	logic                  next_wready;
	logic                  next_bvalid;
	logic [1:0]            next_bresp;
	logic                  next_arready;
	logic                  next_rvalid;
	logic [31:0]           next_rdata;
	logic [1:0]            next_rresp;
	logic                  doWrite;
	logic                  intStatusWrite;
	logic                  intMaskWrite;
	logic [`HMC_INT_W-1:0] intStatus;
	logic [`HMC_INT_W-1:0] intMask;
	logic [`HMC_INT_W-1:0] intEvents;
	logic [1:0]            throttleSync;
	logic                  next_cpu1Oe;
	logic                  next_cpu2Oe;
	logic                  throttleSeen;
	logic                  next_throttleSeen;
	logic [7:0]            oeHist;
	logic [7:0]            next_oeHist;
	hmc_fan_t              next_fan;
	logic [`HMC_ERR_W-1:0] errMaskVec;
	logic [`HMC_ERR_W-1:0] next_passedErrors;
	logic                  next_alert;

	// ----------------------------------------------------------------
	// decode helpers
	// ----------------------------------------------------------------
	function automatic logic isMapped(input logic [`HMC_ADDR_W-1:0] a);
		logic hit;
		hit = 1'b0;
		if (a == `HMC_ADDR_CONFIG)
			hit = 1'b1;
		else if (a == `HMC_ADDR_SLEEP)
			hit = 1'b1;
		else if (a == `HMC_ADDR_INT_STATUS)
			hit = 1'b1;
		else if (a == `HMC_ADDR_INT_MASK)
			hit = 1'b1;
		return hit;
	endfunction : isMapped

	function automatic logic [`HMC_ERR_W-1:0] sleepMaskOf(input logic [1:0] code);
		logic [`HMC_ERR_W-1:0] m;
		m = '0;
		case (code)
			`HMC_SLEEP_AWAKE:   m = '0;                                    // R13
			`HMC_SLEEP_LIGHT:   m = lightSleepMask | `HMC_FIXED_LIGHT;     // R14
			`HMC_SLEEP_SUSPEND: m = suspendMask | `HMC_FIXED_SUSPEND;      // R15
			default:            m = deepSleepMask | `HMC_FIXED_DEEP;       // R16
		endcase
		return m;
	endfunction : sleepMaskOf

	// ----------------------------------------------------------------
	// bus slave
	// ----------------------------------------------------------------
	// address and data are taken in either order, one write at a time
	always_comb
	begin
		next_awHeld  = awHeld;
		next_awAddr  = awAddr;
		next_wHeld   = wHeld;
		next_wData   = wData;
		next_wLane0  = wLane0;
		next_bvalid  = s_axi_bvalid;
		next_bresp   = s_axi_bresp;
		next_rvalid  = s_axi_rvalid;
		next_rdata   = s_axi_rdata;
		next_rresp   = s_axi_rresp;
		doWrite      = 1'b0;
		if (s_axi_awvalid && s_axi_awready)
		begin
			next_awHeld = 1'b1;
			next_awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			next_wHeld  = 1'b1;
			next_wData  = s_axi_wdata[7:0];
			next_wLane0 = s_axi_wstrb[0];
		end
		if (s_axi_bvalid && s_axi_bready)
			next_bvalid = 1'b0;
		if (awHeld && wHeld && !s_axi_bvalid)
		begin
			doWrite     = wLane0 && isMapped(awAddr);
			next_awHeld = 1'b0;
			next_wHeld  = 1'b0;
			next_bvalid = 1'b1;
			next_bresp  = isMapped(awAddr) ? `HMC_RESP_OKAY : `HMC_RESP_SLVERR;
		end
		next_awready = !next_awHeld && !next_bvalid;
		next_wready  = !next_wHeld && !next_bvalid;
		if (s_axi_rvalid && s_axi_rready)
			next_rvalid = 1'b0;
		if (s_axi_arvalid && s_axi_arready)
		begin
			next_rvalid = 1'b1;
			next_rresp  = `HMC_RESP_OKAY;
			next_rdata  = '0;
			if (s_axi_araddr == `HMC_ADDR_CONFIG)
				next_rdata[7:0] = cfg;
			else if (s_axi_araddr == `HMC_ADDR_SLEEP)
				next_rdata[1:0] = sleepStateField;                     // R17
			else if (s_axi_araddr == `HMC_ADDR_INT_STATUS)
				next_rdata[`HMC_INT_W-1:0] = intStatus;
			else if (s_axi_araddr == `HMC_ADDR_INT_MASK)
				next_rdata[`HMC_INT_W-1:0] = intMask;
			else
				next_rresp = `HMC_RESP_SLVERR;
		end
		next_arready = !next_rvalid;
		intStatusWrite = doWrite && (awAddr == `HMC_ADDR_INT_STATUS);
		intMaskWrite   = doWrite && (awAddr == `HMC_ADDR_INT_MASK);
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			awHeld        <= 1'b0;
			awAddr        <= '0;
			wHeld         <= 1'b0;
			wData         <= 8'h00;
			wLane0        <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `HMC_RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `HMC_RESP_OKAY;
		end
		else
		begin
			awHeld        <= next_awHeld;
			awAddr        <= next_awAddr;
			wHeld         <= next_wHeld;
			wData         <= next_wData;
			wLane0        <= next_wLane0;
			s_axi_awready <= next_awready;
			s_axi_wready  <= next_wready;
			s_axi_bvalid  <= next_bvalid;
			s_axi_bresp   <= next_bresp;
			s_axi_arready <= next_arready;
			s_axi_rvalid  <= next_rvalid;
			s_axi_rdata   <= next_rdata;
			s_axi_rresp   <= next_rresp;
		end
	end

	// ----------------------------------------------------------------
	// throttle line pins
	// ----------------------------------------------------------------
	hmc_sync #(
		.WIDTH (2)
	) u_throttle_sync (
		.sys_clk (sys_clk),
		.rst     (rst),
		.pinIn   ({cpu2ThrottleLineIn, cpu1ThrottleLineIn}),
		.pinSync (throttleSync)
	);

	// ----------------------------------------------------------------
	// control core
	// ----------------------------------------------------------------
	always_comb
	begin
		next_cfg             = cfg;
		next_sleepStateField = sleepStateField;
		if (doWrite && (awAddr == `HMC_ADDR_CONFIG))
		begin
			if (!cfg.lock)
				next_cfg.start = wData[`HMC_CFG_START];                 // R3 R4
			next_cfg.lock            = cfg.lock | wData[`HMC_CFG_LOCK]; // R4 R5
			next_cfg.globalErrorMask = wData[`HMC_CFG_GMASK];
			next_cfg.alertEn         = wData[`HMC_CFG_ALERT_EN];
			next_cfg.throttleLineTie = wData[`HMC_CFG_TIE];
			next_cfg.reservedBits    = wData[6:5];                      // R12
		end
		if (doWrite && (awAddr == `HMC_ADDR_SLEEP))
			next_sleepStateField = wData[1:0];                          // R13
		next_cfg.ready = cfg.ready | allChannelsValid;                  // R10

		// start clear or global mask hides every error event
		if (!cfg.start || cfg.globalErrorMask)
			errMaskVec = '1;                                            // R1 R2 R6
		else
			errMaskVec = sleepMaskOf(sleepStateField);
		next_passedErrors = errorEvents & ~errMaskVec;
		next_alert        = cfg.alertEn && (|next_passedErrors);        // R7

		next_fan.autoEnable    = cfg.start;                             // R1 R2
		next_fan.useProgrammed = cfg.start;                             // R2
		next_fan.pwm1Duty      = cfg.start ? pwm1AutoDuty : 8'h00;      // R1
		next_fan.pwm2Duty      = cfg.start ? pwm2AutoDuty : 8'h00;      // R1

		// only echo a line pulled low from outside, never our own pull;
		// history covers the sync lag so a stale low of our own pull cannot ping-pong
		next_oeHist = {oeHist[5:0], cpu2ThrottleLineOe, cpu1ThrottleLineOe};
		next_cpu2Oe = cfg.throttleLineTie && !throttleSync[0] && !cpu1ThrottleLineOe
			&& !(oeHist[6] | oeHist[4] | oeHist[2] | oeHist[0]);                                   // R8
		next_cpu1Oe = cfg.throttleLineTie && !throttleSync[1] && !cpu2ThrottleLineOe && !next_cpu2Oe
			&& !(oeHist[7] | oeHist[5] | oeHist[3] | oeHist[1]);                                   // R8
		next_throttleSeen = !(&throttleSync);

		intEvents = '0;
		intEvents[`HMC_INT_ERROR]    = |next_passedErrors;
		intEvents[`HMC_INT_READY]    = next_cfg.ready && !cfg.ready;
		intEvents[`HMC_INT_THROTTLE] = next_throttleSeen && !throttleSeen;
	end

	// external reset clears the lock and forces the deepest sleep state
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			cfg                 <= `HMC_CFG_RESET;                      // R5 R12
			sleepStateField     <= `HMC_SLEEP_RESET;                    // R16
			passedErrors        <= '0;
			alert               <= 1'b0;
			fan                 <= '0;
			cpu1ThrottleLineOut <= 1'b0;
			cpu2ThrottleLineOut <= 1'b0;
			cpu1ThrottleLineOe  <= 1'b0;
			cpu2ThrottleLineOe  <= 1'b0;
			throttleSeen        <= 1'b0;
			oeHist              <= 8'h00;
		end
		else
		begin
			cfg                 <= next_cfg;
			sleepStateField     <= next_sleepStateField;
			passedErrors        <= next_passedErrors;
			alert               <= next_alert;
			fan                 <= next_fan;
			cpu1ThrottleLineOut <= 1'b0;
			cpu2ThrottleLineOut <= 1'b0;
			cpu1ThrottleLineOe  <= next_cpu1Oe;
			cpu2ThrottleLineOe  <= next_cpu2Oe;
			throttleSeen        <= next_throttleSeen;
			oeHist              <= next_oeHist;
		end
	end

	// ----------------------------------------------------------------
	// interrupts
	// ----------------------------------------------------------------
	hmc_irq u_irq (
		.sys_clk     (sys_clk),
		.rst         (rst),
		.eventIn     (intEvents),
		.statusWrite (intStatusWrite),
		.maskWrite   (intMaskWrite),
		.writeData   (wData[`HMC_INT_W-1:0]),
		.status      (intStatus),
		.mask        (intMask),
		.irq         (irq)
	);

endmodule : hmc_ctrl

// >>> verilog/hmc_map.svh
// register addresses, field positions, reset values and fixed masks of the monitor control bank
`ifndef HMC_MAP_SVH
`define HMC_MAP_SVH

// ----------------------------------------------------------------
// register indices and byte addresses (index times four)
// ----------------------------------------------------------------
`define HMC_IDX_CONFIG       8'he3
`define HMC_IDX_SLEEP        8'he4
`define HMC_IDX_INT_STATUS   8'hf0
`define HMC_IDX_INT_MASK     8'hf1
`define HMC_ADDR_CONFIG      12'h38c
`define HMC_ADDR_SLEEP       12'h390
`define HMC_ADDR_INT_STATUS  12'h3c0
`define HMC_ADDR_INT_MASK    12'h3c4
`define HMC_ADDR_W           12

// ----------------------------------------------------------------
// configuration register fields
// ----------------------------------------------------------------
`define HMC_CFG_START        0
`define HMC_CFG_LOCK         1
`define HMC_CFG_GMASK        2
`define HMC_CFG_ALERT_EN     3
`define HMC_CFG_TIE          4
`define HMC_CFG_READY        7
`define HMC_CFG_RESET        8'h00

// ----------------------------------------------------------------
// sleep-state field codes and reset value
// ----------------------------------------------------------------
`define HMC_SLEEP_AWAKE      2'h0
`define HMC_SLEEP_LIGHT      2'h1
`define HMC_SLEEP_SUSPEND    2'h2
`define HMC_SLEEP_DEEP       2'h3
`define HMC_SLEEP_RESET      2'h3

// ----------------------------------------------------------------
// fixed per-state masking of the error vector, plain defaults
// ----------------------------------------------------------------
`define HMC_FIXED_LIGHT      8'h00
`define HMC_FIXED_SUSPEND    8'h00
`define HMC_FIXED_DEEP       8'hff
`define HMC_ERR_W            8

// ----------------------------------------------------------------
// interrupt status bits and bus answers
// ----------------------------------------------------------------
`define HMC_INT_ERROR        0
`define HMC_INT_READY        1
`define HMC_INT_THROTTLE     2
`define HMC_INT_W            3
`define HMC_INT_RESET        3'h0
`define HMC_RESP_OKAY        2'h0
`define HMC_RESP_SLVERR      2'h2

`endif

// >>> verilog/hmc_pkg.sv
// types shared by the monitor control bank
package hmc_pkg;

	// ----------------------------------------------------------------
	// configuration register layout
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       ready;
		logic [1:0] reservedBits;
		logic       throttleLineTie;
		logic       alertEn;
		logic       globalErrorMask;
		logic       lock;
		logic       start;
	} hmc_cfg_t;

	// ----------------------------------------------------------------
	// fan-control outputs steered by the start bit
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       autoEnable;
		logic       useProgrammed;
		logic [7:0] pwm1Duty;
		logic [7:0] pwm2Duty;
	} hmc_fan_t;

endpackage : hmc_pkg

// >>> verilog/hmc_sync.sv
// three-stage pin synchroniser, output moves when stages two and three agree
module hmc_sync #(
	parameter int WIDTH = 2
) (
	input  wire logic             sys_clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] pinIn,
	output logic      [WIDTH-1:0] pinSync
);
	import hmc_pkg::*;

	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;
	logic [WIDTH-1:0] next_pinSync;

	always_comb
	begin
		next_pinSync = pinSync;
		for (int i = 0; i < WIDTH; i++)
		begin
			if (stage2[i] == stage3[i])
				next_pinSync[i] = stage3[i];
		end
	end

	// idle level of the lines is high
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			stage1  <= '1;
			stage2  <= '1;
			stage3  <= '1;
			pinSync <= '1;
		end
		else
		begin
			stage1  <= pinIn;
			stage2  <= stage1;
			stage3  <= stage2;
			pinSync <= next_pinSync;
		end
	end

endmodule : hmc_sync

// >>> verilog/hmc_irq.sv
// sticky interrupt status with write-one-to-clear, mask and one level output
`include "hmc_map.svh"
module hmc_irq (
	input  wire logic                  sys_clk,
	input  wire logic                  rst,
	input  wire logic [`HMC_INT_W-1:0] eventIn,
	input  wire logic                  statusWrite,
	input  wire logic                  maskWrite,
	input  wire logic [`HMC_INT_W-1:0] writeData,
	output logic      [`HMC_INT_W-1:0] status,
	output logic      [`HMC_INT_W-1:0] mask,
	output logic                       irq
);
	import hmc_pkg::*;

	logic [`HMC_INT_W-1:0] next_status;
	logic [`HMC_INT_W-1:0] next_mask;
	logic                  next_irq;

	// a new event wins over a clear in the same cycle
	always_comb
	begin
		next_status = status;
		next_mask   = mask;
		if (statusWrite)
			next_status = status & ~writeData;
		next_status = next_status | eventIn;
		if (maskWrite)
			next_mask = writeData;
		next_irq = |(next_status & next_mask);
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			status <= `HMC_INT_RESET;
			mask   <= `HMC_INT_RESET;
			irq    <= 1'b0;
		end
		else
		begin
			status <= next_status;
			mask   <= next_mask;
			irq    <= next_irq;
		end
	end

endmodule : hmc_irq

// >>> tb/hmc_ctrl_checker.sv
// port assertions of the monitor control bank
`include "hmc_map.svh"
module hmc_ctrl_checker (
	input wire logic                  sys_clk,
	input wire logic                  rst,
	input wire logic [1:0]            s_axi_bresp,
	input wire logic                  s_axi_bvalid,
	input wire logic                  s_axi_bready,
	input wire logic [31:0]           s_axi_rdata,
	input wire logic                  s_axi_rvalid,
	input wire logic                  s_axi_rready,
	input wire logic [`HMC_ERR_W-1:0] errorEvents,
	input wire logic [7:0]            pwm1AutoDuty,
	input wire logic [7:0]            pwm2AutoDuty,
	input wire logic                  cpu1ThrottleLineOut,
	input wire logic                  cpu2ThrottleLineOut,
	input wire hmc_pkg::hmc_fan_t     fan,
	input wire logic [`HMC_ERR_W-1:0] passedErrors,
	input wire logic                  alert
);
	import hmc_pkg::*;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	// ----------------------------------------------------------------
	// bus answers hold until taken
	// ----------------------------------------------------------------
	sequence bWait;
		s_axi_bvalid && !s_axi_bready;
	endsequence
	sequence rWait;
		s_axi_rvalid && !s_axi_rready;
	endsequence
	bresp_hold_a: assert property (bWait |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
	rdata_hold_a: assert property (rWait |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
	rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("rdata upper set");
	// ----------------------------------------------------------------
	// start, masking, alert and pins
	// ----------------------------------------------------------------
	fan_off_a: assert property (!fan.autoEnable |-> fan.pwm1Duty == 8'h00 && fan.pwm2Duty == 8'h00
		&& passedErrors == 8'h00) else $error("stopped fan or errors live");
	fan_follow_a: assert property (fan.autoEnable |-> fan.pwm1Duty == $past(pwm1AutoDuty)
		&& fan.pwm2Duty == $past(pwm2AutoDuty)) else $error("duty not passed");
	prog_limits_a: assert property (fan.useProgrammed == fan.autoEnable) else $error("limits not steered");
	error_subset_a: assert property ((passedErrors & ~$past(errorEvents)) == 8'h00) else $error("error invented");
	alert_cause_a: assert property (alert |-> |passedErrors) else $error("alert without error");
	drain_only_a: assert property (!cpu1ThrottleLineOut && !cpu2ThrottleLineOut) else $error("line driven high");
endmodule : hmc_ctrl_checker

bind hmc_ctrl hmc_ctrl_checker chk (.sys_clk, .rst, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_rdata,
	.s_axi_rvalid, .s_axi_rready, .errorEvents, .pwm1AutoDuty, .pwm2AutoDuty, .cpu1ThrottleLineOut,
	.cpu2ThrottleLineOut, .fan, .passedErrors, .alert);

// >>> tb/test_hmc_ctrl.sv
// self-checking bench of the monitor control bank
`include "hmc_map.svh"
module test_hmc_ctrl;
	timeunit 1ns;
	timeprecision 1ns;
	import hmc_pkg::*;
	logic        sys_clk = 1'b0, rst = 1'b1, awV = 1'b0, wV = 1'b0, bRdy = 1'b0, arV = 1'b0, rRdy = 1'b0;
	logic [11:0] awA = 12'h0, arA = 12'h0;
	logic [31:0] wD = 32'h0;
	logic [7:0]  ev = 8'h0, lm = 8'h0, sm = 8'h0, dm = 8'h0, d1 = 8'h0, d2 = 8'h0, cfgM, slM, c, lf = 8'h63;
	logic        acv = 1'b0, drv1 = 1'b1, drv2 = 1'b1, rdyM;
	wire         awR, wR, bV, arR, rV, t1o, t1e, t2o, t2e, alert, irq;
	wire  [1:0]  bResp, rResp;
	wire  [31:0] rD;
	wire  [7:0]  pe;
	hmc_fan_t    fan;
	int          err_total = 0, num_checks = 0, n, k;
	// open drain with pull-up: low whenever anyone pulls
	wire         t1i = drv1 & ~t1e;
	wire         t2i = drv2 & ~t2e;
	always #25 sys_clk = ~sys_clk;
	hmc_ctrl dut (.sys_clk(sys_clk), .rst(rst), .s_axi_awaddr(awA), .s_axi_awvalid(awV), .s_axi_awready(awR),
		.s_axi_wdata(wD), .s_axi_wstrb(4'hf), .s_axi_wvalid(wV), .s_axi_wready(wR), .s_axi_bresp(bResp),
		.s_axi_bvalid(bV), .s_axi_bready(bRdy), .s_axi_araddr(arA), .s_axi_arvalid(arV), .s_axi_arready(arR),
		.s_axi_rdata(rD), .s_axi_rresp(rResp), .s_axi_rvalid(rV), .s_axi_rready(rRdy), .errorEvents(ev),
		.lightSleepMask(lm), .suspendMask(sm), .deepSleepMask(dm), .allChannelsValid(acv), .pwm1AutoDuty(d1),
		.pwm2AutoDuty(d2), .cpu1ThrottleLineIn(t1i), .cpu1ThrottleLineOut(t1o), .cpu1ThrottleLineOe(t1e),
		.cpu2ThrottleLineIn(t2i), .cpu2ThrottleLineOut(t2o), .cpu2ThrottleLineOe(t2e), .fan(fan),
		.passedErrors(pe), .alert(alert), .irq(irq));
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task close_out;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : close_out
	task chk(input logic [31:0] g, input logic [31:0] e, input string m);
		num_checks++;
		if (g !== e)
		begin
			err_total++;
			$display("Error at %0t: %s got %h expected %h", $time, m, g, e);
		end
	endtask : chk
	task tmo;
		err_total++;
		$display("Error at %0t: bus answer missing", $time);
		close_out();
	endtask : tmo
	function automatic logic [1:0] expResp(input logic [11:0] a);
		return (a inside {`HMC_ADDR_CONFIG, `HMC_ADDR_SLEEP, `HMC_ADDR_INT_STATUS, `HMC_ADDR_INT_MASK})
			? `HMC_RESP_OKAY : `HMC_RESP_SLVERR;
	endfunction : expResp
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr
	function automatic logic [7:0] expPass(input logic [7:0] e);
		if (!cfgM[0] || cfgM[2])
			return 8'h00;
		case (slM[1:0])
			2'h0: return e;
			2'h1: return e & ~(lm | `HMC_FIXED_LIGHT);
			2'h2: return e & ~(sm | `HMC_FIXED_SUSPEND);
			default: return e & ~(dm | `HMC_FIXED_DEEP);
		endcase
	endfunction : expPass
	task wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		awA <= a; awV <= 1'b1; wD <= {24'h0, d}; wV <= 1'b1; bRdy <= 1'b1;
		for (n = 0; n < 40; n++)
		begin
			@(posedge sys_clk);
			if (awV && awR) awV <= 1'b0;
			if (wV && wR) wV <= 1'b0;
			if (bV === 1'b1) break;
		end
		bRdy <= 1'b0;
		if (n == 40) tmo();
		chk(bResp, expResp(a), "bresp");
		// lock freezes start and lock only
		if (a == `HMC_ADDR_CONFIG) cfgM = {1'b0, d[6:2], cfgM[1] ? cfgM[1:0] : d[1:0]};
		if (a == `HMC_ADDR_SLEEP) slM = {6'h0, d[1:0]};
	endtask : wr
	task rd(input logic [11:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		arA <= a; arV <= 1'b1; rRdy <= 1'b1;
		for (n = 0; n < 40; n++)
		begin
			@(posedge sys_clk);
			if (arV && arR) arV <= 1'b0;
			if (rV === 1'b1) break;
		end
		rRdy <= 1'b0;
		if (n == 40) tmo();
		chk(rD, {24'h0, e}, "rdata");
		chk(rResp, expResp(a), "rresp");
	endtask : rd
	task settle;
		repeat (3) @(posedge sys_clk);
		#5;
	endtask : settle
	task doReset(input int cyc);
		rst <= 1'b1;
		repeat (cyc) @(posedge sys_clk);
		rst <= 1'b0;
		cfgM = `HMC_CFG_RESET; slM = {6'h0, `HMC_SLEEP_RESET}; rdyM = 1'b0;
	endtask : doReset
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	initial
	begin
		doReset(12);
		rd(`HMC_ADDR_CONFIG, 8'h00);
		rd(`HMC_ADDR_SLEEP, 8'h03);
		rd(`HMC_ADDR_INT_STATUS, 8'h00);
		rd(`HMC_ADDR_INT_MASK, 8'h00);
		rd(12'h004, 8'h00);
		wr(12'h004, 8'hff);
		$display("reset values done");
		wr(`HMC_ADDR_CONFIG, 8'he8);
		rd(`HMC_ADDR_CONFIG, {rdyM, cfgM[6:0]});
		wr(`HMC_ADDR_SLEEP, 8'hfe);
		rd(`HMC_ADDR_SLEEP, slM);
		$display("access kinds done");
		for (k = 0; k < 20; k++)
		begin
			c = (k < 16 ? 8'h01 : 8'h00) | (k[2] ? 8'h08 : 8'h00) | (k >= 12 && k < 16 ? 8'h04 : 8'h00);
			wr(`HMC_ADDR_CONFIG, c);
			wr(`HMC_ADDR_SLEEP, {6'h0, k[1:0]});
			lf = lfsr(lf);
			ev <= lf; lm <= lf ^ 8'h5a; sm <= ~lf; dm <= lf >> 1; d1 <= lf; d2 <= ~lf;
			settle();
			chk(pe, expPass(ev), "passed errors");
			chk(alert, cfgM[3] & |expPass(ev), "alert");
			chk(fan, cfgM[0] ? {2'b11, d1, d2} : 18'h0, "fan");
		end
		$display("masking done");
		wr(`HMC_ADDR_CONFIG, 8'h01);
		wr(`HMC_ADDR_SLEEP, 8'h00);
		ev <= 8'h01;
		wr(`HMC_ADDR_INT_MASK, 8'h01);
		settle();
		chk(irq, 1'b1, "irq raised");
		ev <= 8'h00;
		wr(`HMC_ADDR_INT_STATUS, 8'h01);
		rd(`HMC_ADDR_INT_STATUS, 8'h00);
		chk(irq, 1'b0, "irq cleared");
		wr(`HMC_ADDR_INT_MASK, 8'h00);
		ev <= 8'h01;
		settle();
		chk(irq, 1'b0, "irq masked");
		rd(`HMC_ADDR_INT_STATUS, 8'h01);
		$display("interrupts done");
		acv <= 1'b1;
		settle();
		rdyM = 1'b1;
		rd(`HMC_ADDR_CONFIG, {rdyM, cfgM[6:0]});
		rd(`HMC_ADDR_INT_STATUS, 8'h03);
		$display("ready done");
		wr(`HMC_ADDR_CONFIG, 8'h10);
		drv1 <= 1'b0;
		for (k = 0; k < 20 && t2e !== 1'b1; k++) @(posedge sys_clk);
		chk(t2e, 1'b1, "tie pull");
		chk(t1e, 1'b0, "no echo");
		drv1 <= 1'b1;
		for (k = 0; k < 20 && t2e !== 1'b0; k++) @(posedge sys_clk);
		chk(t2e, 1'b0, "tie release");
		repeat (12) @(posedge sys_clk);
		chk({t1e, t2e}, 2'b00, "no ping-pong");
		wr(`HMC_ADDR_CONFIG, 8'h00);
		drv1 <= 1'b0;
		repeat (10) @(posedge sys_clk);
		chk(t2e, 1'b0, "untied");
		drv1 <= 1'b1;
		rd(`HMC_ADDR_INT_STATUS, 8'h07);
		$display("throttle tie done");
		wr(`HMC_ADDR_CONFIG, 8'h03);
		wr(`HMC_ADDR_CONFIG, 8'h6c);
		rd(`HMC_ADDR_CONFIG, {rdyM, cfgM[6:0]});
		wr(`HMC_ADDR_CONFIG, 8'h00);
		rd(`HMC_ADDR_CONFIG, {rdyM, cfgM[6:0]});
		wr(`HMC_ADDR_SLEEP, 8'h01);
		acv <= 1'b0;
		doReset(2);
		rd(`HMC_ADDR_CONFIG, 8'h00);
		rd(`HMC_ADDR_SLEEP, 8'h03);
		$display("lock done");
		close_out();
	end
endmodule : test_hmc_ctrl
